/* src/if_counter_pkg.sv */
// constants, types and register map of the intermediate-frequency counter
package if_counter_pkg;

	localparam int unsigned   CLK_PERIOD_NS  = 25;
	localparam int unsigned   TICK_PERIOD_NS = 1000000;
	localparam int unsigned   TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

	localparam int unsigned   ADDR_W         = 18;
	localparam logic [15:0]   MODE_IDX       = 16'hFFA9;
	localparam logic [15:0]   STATUS_IDX     = 16'hFFAB;
	localparam logic [15:0]   CTRL_IDX       = 16'hFFAC;
	localparam logic [15:0]   COUNT_IDX      = 16'hFFAE;

	localparam int unsigned   CLEAR_BIT      = 0;
	localparam int unsigned   START_BIT      = 1;
	localparam int unsigned   GATE_LSB       = 0;
	localparam int unsigned   PIN_LSB        = 2;

	localparam logic [3:0]    MODE_RESET     = 4'h0;
	localparam logic [15:0]   COUNT_RESET    = 16'h0000;
	localparam logic [15:0]   COUNT_MAX      = 16'hFFFF;

	localparam logic [1:0]    GATE_1MS       = 2'h0;
	localparam logic [1:0]    GATE_4MS       = 2'h1;
	localparam logic [1:0]    GATE_8MS       = 2'h2;
	localparam logic [1:0]    GATE_OPEN_SEL  = 2'h3;
	localparam logic [3:0]    TICKS_1MS      = 4'h1;
	localparam logic [3:0]    TICKS_4MS      = 4'h4;
	localparam logic [3:0]    TICKS_8MS      = 4'h8;

	localparam logic [1:0]    PIN_OFF        = 2'h0;
	localparam logic [1:0]    PIN_AM_AM      = 2'h1;
	localparam logic [1:0]    PIN_FM_FM      = 2'h2;
	localparam logic [1:0]    PIN_FM_AM      = 2'h3;

	typedef enum logic [1:0] {
		GATE_IDLE,
		GATE_ARMED,
		GATE_TIMED,
		GATE_HELD
	} gate_t;

endpackage

/* src/tick_divider.sv */
// divider making the 1 kHz gate tick from the system clock
module tick_divider
	import if_counter_pkg::*;
#(
	parameter int unsigned TICK_LEN = TICK_CYCLES
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic restart,
	output logic      tick
);
	localparam int unsigned CNT_W = $clog2(TICK_LEN);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             tick;
	} div_state_t;

	div_state_t state;
	div_state_t next_state;

	always_comb begin
		next_state = state;
		next_state.tick = 1'b0;
		if (restart) begin
			next_state.cnt = '0;
		end else if (state.cnt == CNT_W'(TICK_LEN - 1)) begin
			next_state.cnt = '0;
			next_state.tick = 1'b1;
		end else begin
			next_state.cnt = state.cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign tick = state.tick;

endmodule

/* src/if_input_conditioner.sv */
// pin synchroniser, selection, edge detect and fm divide-by-two in fm-fm mode
module if_input_conditioner
	import if_counter_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       restart,
	input  wire logic [1:0] pin_mode,
	input  wire logic       am_if_in,
	input  wire logic       fm_if_in,
	output logic            count_pulse
);
	typedef struct packed {
		logic [1:0] am_sync;
		logic [1:0] fm_sync;
		logic       prev;
		logic       half;
		logic       pulse;
	} cond_state_t;

	cond_state_t state;
	cond_state_t next_state;
	logic        sel;
	logic        rise;

	always_comb begin
		next_state = state;
		next_state.am_sync = {state.am_sync[0], am_if_in};
		next_state.fm_sync = {state.fm_sync[0], fm_if_in};
		unique case (pin_mode)
			PIN_OFF:   sel = 1'b0;
			PIN_AM_AM: sel = state.am_sync[1];
			PIN_FM_FM: sel = state.fm_sync[1];
			PIN_FM_AM: sel = state.fm_sync[1];
		endcase
		rise = sel & ~state.prev;
		next_state.prev = sel;
		next_state.pulse = 1'b0;
		if (restart) begin
			next_state.half = 1'b0;
		end else if (rise) begin
			if (pin_mode == PIN_FM_FM) begin
				next_state.half = ~state.half;
				next_state.pulse = state.half;
			end else begin
				next_state.pulse = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign count_pulse = state.pulse;

endmodule

/* src/if_frequency_counter.sv */
// gated intermediate-frequency counter with apb register access
module if_frequency_counter
	import if_counter_pkg::*;
#(
	parameter int unsigned TICK_LEN = TICK_CYCLES
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              am_if_in,
	input  wire logic              fm_if_in,
	input  wire logic              halt,
	input  wire logic              deep_stop,
	output logic                   am_bias_en,
	output logic                   fm_bias_en,
	output logic                   gate_open
);
	localparam logic [ADDR_W-1:0] MODE_ADDR   = {MODE_IDX, 2'b00};
	localparam logic [ADDR_W-1:0] STATUS_ADDR = {STATUS_IDX, 2'b00};
	localparam logic [ADDR_W-1:0] CTRL_ADDR   = {CTRL_IDX, 2'b00};
	localparam logic [ADDR_W-1:0] COUNT_ADDR  = {COUNT_IDX, 2'b00};

	typedef struct packed {
		logic [3:0]  mode;
		gate_t       gate;
		logic        flag;
		logic [3:0]  ticks_left;
		logic [15:0] count;
		logic        am_bias;
		logic        fm_bias;
		logic [31:0] rdata;
	} ctr_state_t;

	localparam ctr_state_t STATE_RESET = '{
		mode:       MODE_RESET,
		gate:       GATE_IDLE,
		flag:       1'b0,
		ticks_left: 4'h0,
		count:      COUNT_RESET,
		am_bias:    1'b0,
		fm_bias:    1'b0,
		rdata:      32'h0000_0000
	};

	ctr_state_t state;
	ctr_state_t next_state;
	logic       tick;
	logic       count_pulse;
	logic       wr;
	logic       hit;
	logic [1:0] gate_sel;
	logic [1:0] pin_sel;
	logic [1:0] new_gate_sel;
	logic       clear_wr;
	logic       start_wr;

	tick_divider #(
		.TICK_LEN (TICK_LEN)
	) u_tick (
		.pclk    (pclk),
		.presetn (presetn),
		.restart (deep_stop),
		.tick    (tick)
	);

	if_input_conditioner u_cond (
		.pclk        (pclk),
		.presetn     (presetn),
		.restart     (deep_stop),
		.pin_mode    (pin_sel),
		.am_if_in    (am_if_in),
		.fm_if_in    (fm_if_in),
		.count_pulse (count_pulse)
	);

	function automatic logic [3:0] gate_ticks(input logic [1:0] sel);
		unique case (sel)
			GATE_1MS: gate_ticks = TICKS_1MS;
			GATE_4MS: gate_ticks = TICKS_4MS;
			GATE_8MS: gate_ticks = TICKS_8MS;
			default:  gate_ticks = 4'h0;
		endcase
	endfunction

	assign gate_sel = state.mode[GATE_LSB +: 2];
	assign pin_sel  = state.mode[PIN_LSB +: 2];
	assign wr       = psel & penable & pwrite;
	assign hit      = (paddr == MODE_ADDR) | (paddr == STATUS_ADDR) |
	                  (paddr == CTRL_ADDR) | (paddr == COUNT_ADDR);
	assign new_gate_sel = pwdata[GATE_LSB +: 2];
	assign clear_wr = wr & (paddr == CTRL_ADDR) & pwdata[CLEAR_BIT];
	assign start_wr = wr & (paddr == CTRL_ADDR) & pwdata[START_BIT];

	// zero-wait slave: every access completes in its first access cycle
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit;

	always_comb begin
		next_state = state;

		// read word taken in the setup cycle, so prdata leaves a flop with no wait state
		next_state.rdata = 32'h0000_0000;
		if (psel && !penable && !pwrite) begin
			unique case (paddr)
				MODE_ADDR:   next_state.rdata = {28'h0000000, state.mode};
				STATUS_ADDR: next_state.rdata = {31'h00000000, state.flag};
				COUNT_ADDR:  next_state.rdata = {16'h0000, state.count};
				default:     next_state.rdata = 32'h0000_0000;
			endcase
		end

		// gate timing; halt keeps a pending gate from opening until halt is released
		unique case (state.gate)
			GATE_IDLE: begin
			end
			GATE_ARMED: begin
				if (tick && !halt) begin
					next_state.gate = GATE_TIMED;
					next_state.ticks_left = gate_ticks(gate_sel);
				end
			end
			GATE_TIMED: begin
				if (tick) begin
					if (state.ticks_left == 4'h1) begin
						next_state.gate = GATE_IDLE;
						next_state.flag = 1'b0;
					end else begin
						next_state.ticks_left = state.ticks_left - 4'h1;
					end
				end
			end
			GATE_HELD: begin
			end
		endcase

		// counting continues in halt; saturation does not end the gate
		if ((state.gate == GATE_TIMED || state.gate == GATE_HELD) && count_pulse &&
		    state.count != COUNT_MAX) begin
			next_state.count = state.count + 16'h0001;
		end

		if (wr && paddr == MODE_ADDR) begin
			next_state.mode = pwdata[3:0];
			if (new_gate_sel == GATE_OPEN_SEL) begin
				next_state.gate = GATE_HELD;
				next_state.flag = 1'b1;
			end else if (state.gate == GATE_HELD) begin
				next_state.gate = GATE_IDLE;
				next_state.flag = 1'b0;
			end
		end

		if (clear_wr) begin
			next_state.count = COUNT_RESET;
		end
		// start during a held gate is ignored; the gate simply stays open
		if (start_wr && state.gate != GATE_HELD && gate_sel != GATE_OPEN_SEL) begin
			next_state.gate = GATE_ARMED;
			next_state.flag = 1'b1;
		end

		// pin bias follows the selection, frozen while halted
		if (!halt) begin
			next_state.am_bias = (next_state.mode[PIN_LSB +: 2] == PIN_AM_AM);
			next_state.fm_bias = (next_state.mode[PIN_LSB +: 2] == PIN_FM_FM) ||
			                     (next_state.mode[PIN_LSB +: 2] == PIN_FM_AM);
		end

		if (deep_stop) begin
			next_state = STATE_RESET;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= STATE_RESET;
		end else begin
			state <= next_state;
		end
	end

	assign prdata     = state.rdata;
	assign am_bias_en = state.am_bias;
	assign fm_bias_en = state.fm_bias;
	assign gate_open  = (state.gate == GATE_TIMED) || (state.gate == GATE_HELD);

endmodule

/* test/if_source.sv */
// intermediate-frequency signal source for the two counter pins
module if_source (
	input  wire logic pclk,
	input  wire logic am_on,
	input  wire logic fm_on,
	output logic      am_if_in,
	output logic      fm_if_in
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] ph = 2'h0;
	// two cycles high, two low: the narrowest pulse the synchroniser must see
	always @(posedge pclk) begin
		ph <= ph + 2'h1;
		am_if_in <= am_on & ph[1];
		fm_if_in <= fm_on & ph[1];
	end
endmodule

/* test/if_frequency_counter_chk.sv */
// port assertions for the intermediate-frequency counter
module if_frequency_counter_chk
	import if_counter_pkg::*;
#(
	parameter int unsigned TICK_LEN = TICK_CYCLES
) (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              halt,
	input wire logic              deep_stop,
	input wire logic              am_bias_en,
	input wire logic              fm_bias_en,
	input wire logic              gate_open
);
	timeunit 1ns;
	timeprecision 100ps;
	logic        mode_wr;
	logic        ctrl_wr;
	logic        stat_rd;
	logic        held;
	logic [3:0]  mode_q;
	logic [3:0]  ticks;
	logic        open_d;
	logic [15:0] len;
	logic [15:0] exp_len;
	assign mode_wr = psel && penable && pwrite && paddr == {MODE_IDX, 2'b00};
	assign ctrl_wr = psel && penable && pwrite && paddr == {CTRL_IDX, 2'b00};
	assign stat_rd = psel && penable && !pwrite && paddr == {STATUS_IDX, 2'b00};
	assign held = mode_q[1:0] == GATE_OPEN_SEL;
	assign ticks = mode_q[1:0] == GATE_1MS ? TICKS_1MS : mode_q[1:0] == GATE_4MS ? TICKS_4MS :
		mode_q[1:0] == GATE_8MS ? TICKS_8MS : 4'h0;
	// shadow of the mode field, so gate length can be judged from the ports
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= 4'h0;
			open_d <= 1'h0;
			len <= 16'h0000;
			exp_len <= 16'h0000;
		end else begin
			mode_q <= deep_stop ? 4'h0 : (mode_wr ? pwdata[3:0] : mode_q);
			open_d <= gate_open;
			len <= gate_open ? len + 16'h0001 : 16'h0000;
			if (gate_open && !open_d)
				exp_len <= 16'(TICK_LEN) * {12'h000, ticks};
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence open_wr_s;
		mode_wr && pwdata[1:0] == GATE_OPEN_SEL && !deep_stop;
	endsequence
	sequence start_wr_s;
		ctrl_wr && pwdata[START_BIT] && !held && !deep_stop;
	endsequence
	open_at_once_a: assert property (open_wr_s |=> gate_open) else $error("open gate late");
	open_no_close_a: assert property (gate_open && held && !mode_wr && !deep_stop |=> gate_open)
		else $error("held gate closed");
	held_close_a: assert property (gate_open && held && mode_wr && pwdata[1:0] != GATE_OPEN_SEL && !deep_stop
		|=> !gate_open) else $error("held gate not closed");
	wait_tick_a: assert property (start_wr_s ##0 !gate_open |=> !gate_open) else $error("gate opened early");
	gate_len_a: assert property ($fell(gate_open) && exp_len != 16'h0000 && !$past(deep_stop) |-> len == exp_len)
		else $error("gate length wrong");
	flag_read_a: assert property (stat_rd && gate_open |-> prdata == 32'h0000_0001) else $error("flag low");
	stop_clears_a: assert property (deep_stop |=> !gate_open && !am_bias_en && !fm_bias_en)
		else $error("deep stop kept state");
	halt_holds_a: assert property (halt && !deep_stop |=> $stable(am_bias_en) && $stable(fm_bias_en))
		else $error("pin state moved in halt");
	bias_sel_a: assert property (mode_wr && !halt && !deep_stop |-> ##[1:2]
		am_bias_en == (mode_q[3:2] == PIN_AM_AM) && fm_bias_en == mode_q[3]) else $error("pin select wrong");
endmodule
bind if_frequency_counter if_frequency_counter_chk #(.TICK_LEN(TICK_LEN)) chk (.pclk, .presetn, .paddr, .psel,
	.penable, .pwrite, .pwdata, .prdata, .halt, .deep_stop, .am_bias_en, .fm_bias_en, .gate_open);

/* test/tb_if_frequency_counter.sv */
// self-checking testbench for the intermediate-frequency counter
module tb_if_frequency_counter
	import if_counter_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int unsigned TL     = 20;
	localparam logic [17:0] A_MODE = {MODE_IDX, 2'b00};
	localparam logic [17:0] A_STAT = {STATUS_IDX, 2'b00};
	localparam logic [17:0] A_CTRL = {CTRL_IDX, 2'b00};
	localparam logic [17:0] A_CNT  = {COUNT_IDX, 2'b00};
	logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic        halt = 1'h0, deep_stop = 1'h0, am_on = 1'h0, fm_on = 1'h0;
	logic [17:0] paddr = 18'h00000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, am_if_in, fm_if_in, am_bias_en, fm_bias_en, gate_open, err;
	int          err_total = 0, n_compared = 0;
	if_frequency_counter #(.TICK_LEN(TL)) uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .am_if_in, .fm_if_in, .halt, .deep_stop, .am_bias_en, .fm_bias_en, .gate_open);
	if_source src (.pclk, .am_on, .fm_on, .am_if_in, .fm_if_in);
	task automatic summarize();
		if (err_total == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [17:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic gate_cycle(output bit seen);
		seen = 1'h0;
		for (int i = 0; i < 400 && !(seen && !gate_open); i++) begin
			@(negedge pclk);
			seen |= gate_open;
		end
	endtask
	// count within one of the ideal figure: a gate may catch one extra edge
	task automatic measure(input logic [3:0] m, input logic a, input logic f, input int e);
		bit o;
		am_on <= a;
		fm_on <= f;
		xfer(1'h1, A_MODE, {28'h0, m});
		repeat (4) @(posedge pclk);
		xfer(1'h1, A_CTRL, 32'h1);
		xfer(1'h1, A_CTRL, 32'h2);
		xfer(1'h0, A_STAT, 32'h0);
		check(rd, 32'h1);
		check({am_bias_en, fm_bias_en}, {m[3:2] == PIN_AM_AM, m[3]});
		gate_cycle(o);
		check(o, 1'h1);
		xfer(1'h0, A_STAT, 32'h0);
		check(rd, 32'h0);
		xfer(1'h0, A_CNT, 32'h0);
		check(e == 0 ? rd == 0 : rd + 1 >= e && rd <= e + 1, 1'h1);
	endtask
	task automatic open_test();
		logic [31:0] c;
		am_on <= 1'h1;
		fm_on <= 1'h0;
		xfer(1'h1, A_MODE, 32'h7);
		@(negedge pclk);
		check(gate_open, 1'h1);
		xfer(1'h0, A_STAT, 32'h0);
		check(rd, 32'h1);
		repeat (200) @(negedge pclk);
		check(gate_open, 1'h1);
		xfer(1'h1, A_MODE, 32'h4);
		@(negedge pclk);
		check(gate_open, 1'h0);
		xfer(1'h0, A_CNT, 32'h0);
		c = rd;
		check(c > 32'h28, 1'h1);
		xfer(1'h1, A_CTRL, 32'h0);
		xfer(1'h0, A_CNT, 32'h0);
		check(rd, c);
		xfer(1'h1, A_CTRL, 32'h1);
		xfer(1'h0, A_CNT, 32'h0);
		check(rd, 32'h0);
	endtask
	task automatic standby();
		bit o;
		o = 1'h0;
		xfer(1'h1, A_MODE, 32'h4);
		xfer(1'h1, A_CTRL, 32'h2);
		halt <= 1'h1;
		xfer(1'h1, A_MODE, 32'h0);
		for (int i = 0; i < 3 * TL; i++) begin
			@(negedge pclk);
			o |= gate_open;
		end
		check(o, 1'h0);
		check(am_bias_en, 1'h1);
		@(posedge pclk);
		halt <= 1'h0;
		gate_cycle(o);
		check({o, am_bias_en}, 2'h2);
		xfer(1'h1, A_MODE, 32'hB);
		deep_stop <= 1'h1;
		@(posedge pclk);
		deep_stop <= 1'h0;
		@(negedge pclk);
		check({gate_open, fm_bias_en}, 2'h0);
		xfer(1'h0, A_MODE, 32'h0);
		check(rd, 32'h0);
	endtask
	initial begin
		forever #12.5 pclk = ~pclk;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		err_total++;
		summarize();
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		for (int i = 0; i < 4; i++) begin
			xfer(1'h0, i == 0 ? A_MODE : i == 1 ? A_STAT : i == 2 ? A_CTRL : A_CNT, 32'h0);
			check(rd, 32'h0);
		end
		xfer(1'h0, 18'h00000, 32'h0);
		check(err, 1'h1);
		check(rd, 32'h0);
		measure(4'h4, 1'h1, 1'h0, TL / 4);
		measure(4'h5, 1'h1, 1'h0, TL);
		measure(4'h6, 1'h1, 1'h0, 2 * TL);
		measure(4'h9, 1'h0, 1'h1, TL / 2);
		measure(4'hD, 1'h0, 1'h1, TL);
		measure(4'h5, 1'h0, 1'h1, 0);
		measure(4'h1, 1'h1, 1'h1, 0);
		open_test();
		standby();
		summarize();
	end
endmodule
